//--- tps_pkg.sv
// constants, state codes and helpers for the timer prescale and stretch block
package tps_pkg;

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [7:0] CTL_ADDR = 8'h8E;
   localparam logic [7:0] PERMIT_ADDR = 8'h8F;
   localparam logic [7:0] CTL_RESET = 8'h01;
   localparam logic [7:0] PERMIT_RESET = 8'h00;
   localparam logic [7:0] CTL_MASK = 8'h3F;
   localparam logic [7:0] PERMIT_MASK = 8'h01;
   localparam int T2_SEL_BIT = 5;
   localparam int T1_SEL_BIT = 4;
   localparam int T0_SEL_BIT = 3;
   localparam int STRETCH_LSB = 0;
   localparam int STRETCH_MSB = 2;
   localparam int PERMIT_BIT = 0;

   // -------------------------------------------------------------
   // timing counts in system clocks and instruction cycles
   // -------------------------------------------------------------
   localparam logic [3:0] DIV_SLOW_LAST = 4'hB;
   localparam logic [1:0] DIV_FAST_LAST = 2'h3;
   localparam logic [5:0] CLKS_PER_ICYCLE = 6'h04;
   localparam logic [5:0] BASE_ICYCLES = 6'h02;
   localparam logic [5:0] SETUP_CLKS = 6'h02;
   localparam logic [5:0] ZERO_STRETCH_STROBE = 6'h02;
   localparam logic [5:0] STROBE_PER_STEP = 6'h04;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_HOLD = 4'b1000
   } move_state_type;

   // whole move length in clocks for stretch value n
   function automatic logic [5:0] move_clks(input logic [2:0] n);
      move_clks = 6'((BASE_ICYCLES + {3'h0, n}) * CLKS_PER_ICYCLE);
   endfunction : move_clks

   // strobe width in clocks for stretch value n
   function automatic logic [5:0] strobe_clks(input logic [2:0] n);
      strobe_clks = (n == 3'h0) ? ZERO_STRETCH_STROBE : 6'({3'h0, n} * STROBE_PER_STEP);
   endfunction : strobe_clks

endpackage : tps_pkg

//--- timer_prescale_external_data_move_stretch.sv
// timer prescale ticks, external data move strobe stretching and flash write gate
// Summary of operation
// RL1 - timer2 tick divides by 12 or 4
// RL2 - timer2 select ignored in baud/clock-out mode
// RL3 - timer1 tick divides by 12 or 4
// RL4 - timer0 tick divides by 12 or 4
// RL5 - instruction cycle tick independent of selects
// RL6 - external move lasts stretch plus two cycles
// RL7 - strobe two clocks, else four per step
// RL8 - control resets to 01, top bits zero
// RL9 - internal SRAM moves always two cycles
// RL10 - stretching only lengthens, data unchanged
// RL11 - permit clear blocks flash writes
// RL12 - permit set allows unless locks active
// RL13 - new stretch applies to next move
`timescale 1ns/1ps
module timer_prescale_external_data_move_stretch
   import tps_pkg::*;
(
   // clock, reset, freeze
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   // special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // timer clocking
   input wire logic timer2_baud_or_clkout,
   output logic timer0_tick,
   output logic timer1_tick,
   output logic timer2_tick,
   output logic icycle_tick,
   // lock settings from hardware_config_byte_zero
   input wire logic program_memory_lock,
   input wire logic reset_sector_lock,
   // external_data_move requests from the core
   input wire logic move_req,
   input wire logic move_write,
   input wire logic move_target_sram,
   input wire logic move_target_flash,
   input wire logic [15:0] move_addr,
   input wire logic [7:0] move_wdata,
   output logic move_done,
   output logic [7:0] move_rdata,
   output logic flash_wr_pulse,
   output logic flash_wr_blocked,
   // external memory pins
   output logic [15:0] ext_addr,
   input wire logic [7:0] ext_data_in,
   output logic [7:0] ext_data_out,
   output logic ext_data_oe,
   output logic ext_rd_n,
   output logic ext_wr_n
);

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [7:0] ctl_ff;
   logic [7:0] permit_ff;
   logic [7:0] rdata_ff;
   logic [3:0] div_ff;
   logic t0_ff, t1_ff, t2_ff, ic_ff;
   move_state_type state_ff;
   move_state_type nxt_state;
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic [2:0] stretch_ff;
   logic write_ff, ext_ff, flash_ff;
   logic done_ff, fpulse_ff, fblock_ff;
   logic [7:0] mrdata_ff, wdata_ff;
   logic [15:0] addr_ff;
   logic oe_ff, rd_n_ff, wr_n_ff;

   // -------------------------------------------------------------
   // decode and next values
   // -------------------------------------------------------------
   // register select and read mux
   wire ctl_hit = (sfr_addr == CTL_ADDR);
   wire permit_hit = (sfr_addr == PERMIT_ADDR);
   wire [7:0] read_mux;
   assign read_mux = ctl_hit ? ctl_ff : (permit_hit ? permit_ff : 8'h00);

   // prescale: one mod-12 counter feeds both rates, so a 12 tick is also a 4 tick
   wire [3:0] nxt_div = (div_ff == DIV_SLOW_LAST) ? 4'h0 : div_ff + 4'h1;
   wire slow_hit = (div_ff == DIV_SLOW_LAST);
   wire fast_hit = (div_ff[1:0] == DIV_FAST_LAST);
   wire baud_hit = div_ff[0];
   wire nxt_t0 = ctl_ff[T0_SEL_BIT] ? fast_hit : slow_hit; // RL4
   wire nxt_t1 = ctl_ff[T1_SEL_BIT] ? fast_hit : slow_hit; // RL3
   wire nxt_t2_sel = ctl_ff[T2_SEL_BIT] ? fast_hit : slow_hit; // RL1
   wire nxt_t2 = timer2_baud_or_clkout ? baud_hit : nxt_t2_sel; // RL2
   // instruction cycle never looks at the select bits
   wire nxt_ic = fast_hit; // RL5

   // move sequencing
   wire busy = (state_ff != ST_IDLE);
   wire take = (state_ff == ST_IDLE) && move_req;
   wire take_ext = !move_target_sram && !move_target_flash;
   // internal targets run at the unstretched rate
   wire [5:0] len = ext_ff ? move_clks(stretch_ff) : move_clks(3'h0); // RL6 RL9
   wire [5:0] strobe_end = SETUP_CLKS + strobe_clks(stretch_ff); // RL7
   wire last = busy && (cnt_ff == len - 6'h01);
   assign nxt_cnt = take ? 6'h01 : ((last || !busy) ? 6'h00 : cnt_ff + 6'h01);
   wire in_strobe = ext_ff && (nxt_cnt > SETUP_CLKS) && (nxt_cnt <= strobe_end);
   wire flash_ok = permit_ff[PERMIT_BIT] && !program_memory_lock && !reset_sector_lock;
   wire fl_end = last && flash_ff && write_ff;

   // next state from elapsed count
   always_comb
   begin
      nxt_state = ST_IDLE;
      if (take)
      begin
         nxt_state = ST_SETUP;
      end
      else if (busy && !last)
      begin
         if (in_strobe)
         begin
            nxt_state = ST_STROBE;
         end
         else if (nxt_cnt > SETUP_CLKS)
         begin
            nxt_state = ST_HOLD;
         end
         else
         begin
            nxt_state = ST_SETUP;
         end
      end
   end

   // strobe pins and data capture
   wire nxt_rd_n = !((nxt_state == ST_STROBE) && !write_ff);
   wire nxt_wr_n = !((nxt_state == ST_STROBE) && write_ff);
   wire cap = (state_ff == ST_STROBE) && (nxt_state != ST_STROBE) && !write_ff;
   wire nxt_oe = take ? (take_ext && move_write) : (last ? 1'b0 : oe_ff);

   // -------------------------------------------------------------
   // register file
   // -------------------------------------------------------------
   // reserved bits are masked on write so they read as zero
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctl_ff <= CTL_RESET; // RL8
         permit_ff <= PERMIT_RESET;
         rdata_ff <= 8'h00;
      end
      else if (ce)
      begin
         if (sfr_wr && ctl_hit)
         begin
            ctl_ff <= sfr_wdata & CTL_MASK; // RL8
         end
         if (sfr_wr && permit_hit)
         begin
            permit_ff <= sfr_wdata & PERMIT_MASK;
         end
         rdata_ff <= sfr_rd ? read_mux : 8'h00;
      end
   end

   // -------------------------------------------------------------
   // prescaler
   // -------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_ff <= 4'h0;
         t0_ff <= 1'b0;
         t1_ff <= 1'b0;
         t2_ff <= 1'b0;
         ic_ff <= 1'b0;
      end
      else if (ce)
      begin
         div_ff <= nxt_div;
         t0_ff <= nxt_t0;
         t1_ff <= nxt_t1;
         t2_ff <= nxt_t2;
         ic_ff <= nxt_ic;
      end
   end

   // -------------------------------------------------------------
   // move sequencer
   // -------------------------------------------------------------
   // stretch is latched at the take, so a rewrite mid-move waits
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff <= ST_IDLE;
         cnt_ff <= 6'h00;
         stretch_ff <= 3'h0;
         write_ff <= 1'b0;
         ext_ff <= 1'b0;
         flash_ff <= 1'b0;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         if (take)
         begin
            stretch_ff <= ctl_ff[STRETCH_MSB:STRETCH_LSB]; // RL13
            write_ff <= move_write;
            ext_ff <= take_ext;
            flash_ff <= move_target_flash;
         end
      end
   end

   // pins, data and completion pulses
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         addr_ff <= 16'h0000;
         wdata_ff <= 8'h00;
         mrdata_ff <= 8'h00;
         oe_ff <= 1'b0;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         done_ff <= 1'b0;
         fpulse_ff <= 1'b0;
         fblock_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (take && take_ext)
         begin
            addr_ff <= move_addr;
            wdata_ff <= move_wdata;
         end
         if (cap)
         begin
            mrdata_ff <= ext_data_in; // RL10
         end
         oe_ff <= nxt_oe;
         rd_n_ff <= nxt_rd_n; // RL7
         wr_n_ff <= nxt_wr_n; // RL7
         done_ff <= last; // RL6
         fpulse_ff <= fl_end && flash_ok; // RL12
         fblock_ff <= fl_end && !flash_ok; // RL11
      end
   end

   assign sfr_rdata = rdata_ff;
   assign timer0_tick = t0_ff;
   assign timer1_tick = t1_ff;
   assign timer2_tick = t2_ff;
   assign icycle_tick = ic_ff;
   assign move_done = done_ff;
   assign move_rdata = mrdata_ff;
   assign flash_wr_pulse = fpulse_ff;
   assign flash_wr_blocked = fblock_ff;
   assign ext_addr = addr_ff;
   assign ext_data_out = wdata_ff;
   assign ext_data_oe = oe_ff;
   assign ext_rd_n = rd_n_ff;
   assign ext_wr_n = wr_n_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // helper counters only the checks read
   logic [5:0] run_ff, elapsed_ff;
   logic ctl_written_ff;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         run_ff <= 6'h00;
         elapsed_ff <= 6'h00;
         ctl_written_ff <= 1'b0;
      end
      else if (ce)
      begin
         run_ff <= (rd_n_ff && wr_n_ff) ? 6'h00 : run_ff + 6'h01;
         elapsed_ff <= take ? 6'h01 : elapsed_ff + 6'h01;
         ctl_written_ff <= ctl_written_ff || (sfr_wr && ctl_hit);
      end
   end

   a_t0_fast_rate: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL4
      ctl_ff[T0_SEL_BIT] && $past(ctl_ff[T0_SEL_BIT]) |-> timer0_tick == icycle_tick)
      else $error("timer0 fast tick not on instruction cycle");
   a_t1_fast_rate: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL3
      ctl_ff[T1_SEL_BIT] && $past(ctl_ff[T1_SEL_BIT]) |-> timer1_tick == icycle_tick)
      else $error("timer1 fast tick not on instruction cycle");
   a_t2_slow_gap: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL1
      timer2_tick && !ctl_ff[T2_SEL_BIT] && !timer2_baud_or_clkout
      && !$past(ctl_ff[T2_SEL_BIT]) && !$past(timer2_baud_or_clkout)
      ##1 (!ctl_ff[T2_SEL_BIT] && !timer2_baud_or_clkout)[*3] |-> !timer2_tick[*3])
      else $error("timer2 slow tick too frequent");
   a_t2_mode_ignore: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL2
      $past(timer2_baud_or_clkout) && $past(timer2_baud_or_clkout, 2) && $past(ce)
      && $past(ce, 2) |-> timer2_tick != $past(timer2_tick))
      else $error("timer2 tick follows select in baud mode");
   a_icycle_period: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL5
      icycle_tick |-> ##1 !icycle_tick[*3] ##1 icycle_tick)
      else $error("instruction cycle tick not every four clocks");
   a_move_length: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL6
      move_done && ext_ff |-> elapsed_ff == move_clks(stretch_ff))
      else $error("external move length wrong");
   a_strobe_width: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL7
      $rose(ext_rd_n && ext_wr_n) |-> run_ff == strobe_clks(stretch_ff))
      else $error("strobe width wrong");
   a_ctl_reset_val: assert property (@(posedge core_clk) disable iff (!resetn) // RL8
      (!ctl_written_ff |-> ctl_ff == CTL_RESET) and (ctl_ff[7:6] == 2'b00))
      else $error("control register reset or reserved bits wrong");
   a_sram_fixed_rate: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL9
      take && move_target_sram |-> ##1 (ext_rd_n && ext_wr_n && !move_done)[*7] ##1 move_done)
      else $error("internal move not two instruction cycles");
   a_read_capture: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL10
      $rose(ext_rd_n) && $past(ce) |-> move_rdata == $past(ext_data_in))
      else $error("read data not taken at strobe end");
   a_flash_gate: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL11
      flash_wr_pulse |-> $past(permit_ff[PERMIT_BIT]))
      else $error("flash write without permit");
   a_flash_locks: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL12
      flash_wr_pulse |-> !$past(program_memory_lock) && !$past(reset_sector_lock))
      else $error("flash write despite lock");
   a_stretch_held: assert property (@(posedge core_clk) disable iff (!resetn || !ce) // RL13
      busy && $past(busy) && $past(ce) |-> $stable(stretch_ff))
      else $error("stretch changed mid move");

endmodule : timer_prescale_external_data_move_stretch

//--- ext_mem_model.sv
// behavioural external memory on the stretched read and write strobes
`timescale 1ns/1ps
module ext_mem_model
#(
   parameter int LATE_CYCLES = 0
)
(
   // clock
   input wire logic core_clk,
   // memory pins
   input wire logic [15:0] ext_addr,
   input wire logic [7:0] ext_data_out,
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   output logic [7:0] ext_data_in
);
   logic [7:0] mem_ff [16];
   logic [7:0] noise_ff = 8'h5A;
   int low_cnt = 0;

   // released bus flips every clock so stale data never looks valid
   always @(posedge core_clk)
   begin
      noise_ff <= ~noise_ff;
      low_cnt <= ext_rd_n ? 0 : low_cnt + 1;
   end

   // a slow part answers only after LATE_CYCLES of strobe
   assign ext_data_in = (!ext_rd_n && low_cnt >= LATE_CYCLES) ? mem_ff[ext_addr[3:0]] : noise_ff;

   // write lands when the strobe rises
   always @(posedge ext_wr_n)
   begin
      mem_ff[ext_addr[3:0]] <= ext_data_out;
   end
endmodule : ext_mem_model

//--- timer_prescale_external_data_move_stretch_bench.sv
// self-checking bench for the timer prescale and stretch block
`timescale 1ns/1ps
module timer_prescale_external_data_move_stretch_bench
   import tps_pkg::*;
();
   typedef struct {time take; int lat; int strobes; bit chk;
      logic [7:0] data; bit fp; bit fb; logic [15:0] addr;} note_type;
   logic core_clk = 1'b0, resetn = 1'b0, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, move_wdata = 8'h00;
   logic timer2_baud_or_clkout = 1'b0, program_memory_lock = 1'b0, reset_sector_lock = 1'b0;
   logic move_req = 1'b0, move_write = 1'b0, move_target_sram = 1'b0, move_target_flash = 1'b0;
   logic [15:0] move_addr = 16'h0000, ext_addr, a7;
   logic [7:0] sfr_rdata, move_rdata, ext_data_in, ext_data_out;
   logic timer0_tick, timer1_tick, timer2_tick, icycle_tick, move_done;
   logic flash_wr_pulse, flash_wr_blocked, ext_data_oe, ext_rd_n, ext_wr_n;
   logic [7:0] sfr_q [$];
   note_type move_q [$];
   logic [7:0] shadow [16];
   logic [31:0] seed = 32'h0000E4DD;
   logic [31:0] r;
   int bad_count = 0, samples_checked = 0, strobe_cnt = 0;
   bit rd_armed = 0, perm = 0;

   always #2 core_clk = ~core_clk;

   timer_prescale_external_data_move_stretch u_timer_prescale_external_data_move_stretch
   (
      .core_clk, .resetn, .ce, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
      .timer2_baud_or_clkout, .timer0_tick, .timer1_tick, .timer2_tick, .icycle_tick,
      .program_memory_lock, .reset_sector_lock, .move_req, .move_write, .move_target_sram,
      .move_target_flash, .move_addr, .move_wdata, .move_done, .move_rdata, .flash_wr_pulse,
      .flash_wr_blocked, .ext_addr, .ext_data_in, .ext_data_out, .ext_data_oe, .ext_rd_n,
      .ext_wr_n
   );

   ext_mem_model u_ext_mem_model
   (
      .core_clk, .ext_addr, .ext_data_out, .ext_rd_n, .ext_wr_n, .ext_data_in
   );

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
      @(posedge core_clk);
      #1 sfr_wr = 1'b0;
   endtask : sfr_write

   // expected byte is noted when the read is launched
   task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      #1 {sfr_addr, sfr_rd} = {a, 1'b1};
      sfr_q.push_back(exp);
      @(posedge core_clk);
      #1 sfr_rd = 1'b0;
   endtask : sfr_read

   // latency counts from the cycle in which the request is held
   task automatic issue_move(input bit w, sram, flash, input logic [15:0] a,
      input logic [7:0] d, input int n);
      note_type nt;
      bit inner;
      inner = sram | flash;
      nt.lat = inner ? 8 : 4 * (n + 2);
      nt.strobes = inner ? 0 : (n == 0 ? 2 : 4 * n);
      nt.chk = !w && !inner;
      nt.data = shadow[a[3:0]];
      nt.addr = a;
      nt.fp = flash && w && perm && !program_memory_lock && !reset_sector_lock;
      nt.fb = flash && w && !nt.fp;
      if (w && !inner)
         shadow[a[3:0]] = d;
      @(posedge core_clk);
      #1 {move_req, move_write, move_target_sram, move_target_flash} = {1'b1, w, sram, flash};
      {move_addr, move_wdata} = {a, d};
      @(posedge core_clk);
      nt.take = $time;
      move_q.push_back(nt);
      #1 move_req = 1'b0;
   endtask : issue_move

   task automatic wait_done();
      int i;
      for (i = 0; i < 80 && move_done !== 1'b1; i++)
         @(negedge core_clk);
      if (i == 80)
         check(1, 0, "move never finished");
   endtask : wait_done

   // -------------------------------------------------------------
   // monitor: pops the oldest note whenever a result shows
   // -------------------------------------------------------------
   always @(negedge core_clk)
   begin
      note_type nt;
      if (rd_armed)
         check(sfr_rdata, sfr_q.pop_front(), "register read");
      rd_armed = (sfr_rd === 1'b1);
      if (ext_rd_n === 1'b0 || ext_wr_n === 1'b0)
         strobe_cnt++;
      // write data must be driven for the whole write strobe
      if (ext_wr_n === 1'b0)
         check(ext_data_oe, 1'b1, "write drive");
      if (move_done === 1'b1)
      begin
         nt = move_q.pop_front();
         check(32'(($time + 2 - nt.take) / 4), nt.lat, "move length");
         check(strobe_cnt, nt.strobes, "strobe width");
         if (nt.chk)
            check(move_rdata, nt.data, "read data");
         check(flash_wr_pulse, nt.fp, "flash accept");
         check(flash_wr_blocked, nt.fb, "flash refuse");
         check(ext_data_oe, 1'b0, "drive released");
         if (nt.strobes != 0)
            check(ext_addr, nt.addr, "strobe address");
         strobe_cnt = 0;
      end
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial
   begin
      logic [7:0] c0, c1, c2, ci;
      repeat (5) @(posedge core_clk);
      #1 resetn = 1'b1;
      sfr_read(CTL_ADDR, 8'h01);
      sfr_read(PERMIT_ADDR, 8'h00);
      sfr_write(8'h90, 8'hFF);
      sfr_read(8'h90, 8'h00);
      // a write while frozen must not land
      ce = 1'b0;
      sfr_write(CTL_ADDR, 8'h3F);
      ce = 1'b1;
      sfr_read(CTL_ADDR, 8'h01);
      $display("test registers done");
      // each select pattern, timer2 mode picked at random
      for (int k = 0; k < 8; k++)
      begin
         r = xs();
         sfr_write(CTL_ADDR, {2'b11, k[2:0], r[3:1]});
         timer2_baud_or_clkout = r[0];
         sfr_read(CTL_ADDR, {2'b00, k[2:0], r[3:1]});
         repeat (24) @(posedge core_clk);
         {c0, c1, c2, ci} = 32'h0;
         repeat (48)
         begin
            @(negedge core_clk);
            {c0, c1, c2, ci} = {c0 + timer0_tick, c1 + timer1_tick, c2 + timer2_tick,
               ci + icycle_tick};
         end
         check(c0, k[0] ? 12 : 4, "timer0 ticks");
         check(c1, k[1] ? 12 : 4, "timer1 ticks");
         check(c2, r[0] ? 24 : (k[2] ? 12 : 4), "timer2 ticks");
         check(ci, 12, "instruction ticks");
      end
      $display("test prescale done");
      for (int n = 0; n < 8; n++)
      begin
         r = xs();
         a7 = r[23:8];
         sfr_write(CTL_ADDR, {2'b00, r[5:3], n[2:0]});
         issue_move(1, 0, 0, a7, r[31:24], n);
         wait_done();
         issue_move(0, 0, 0, a7, 8'h00, n);
         wait_done();
         issue_move(r[0], 1, 0, a7, 8'h00, n);
         wait_done();
      end
      // stretch rewritten mid-move only counts for the next move
      issue_move(0, 0, 0, a7, 8'h00, 7);
      sfr_write(CTL_ADDR, 8'h00);
      wait_done();
      issue_move(0, 0, 0, a7, 8'h00, 0);
      wait_done();
      $display("test stretch done");
      for (int j = 0; j < 8; j++)
      begin
         r = xs();
         perm = j[0];
         sfr_write(PERMIT_ADDR, {r[7:1], perm});
         sfr_read(PERMIT_ADDR, {7'h00, perm});
         {program_memory_lock, reset_sector_lock} = {j[1], j[2]};
         issue_move(1, 0, 1, r[23:8], r[31:24], 0);
         wait_done();
      end
      $display("test flash done");
      repeat (4) @(posedge core_clk);
      conclude();
   end

   // hang guard, far beyond the roughly 1300 cycles the tests take
   initial
   begin
      #80000;
      check(1, 0, "watchdog");
      conclude();
   end
endmodule : timer_prescale_external_data_move_stretch_bench
